// *** hw/tape_gate_pkg.sv ***
package tape_gate_pkg;
  // Register byte offsets
  localparam logic [7:0] CMD_OFS = 8'h00;    // Command launch
  localparam logic [7:0] CTRL_OFS = 8'h04;   // Drive control
  localparam logic [7:0] MEDIA_OFS = 8'h08;  // Media layout report
  localparam logic [7:0] STAT_OFS = 8'h0C;   // Outcome of last command
  localparam logic [7:0] RESID_OFS = 8'h10;  // Residual count
  // Field positions
  localparam int OP_LSB = 0;       // Command opcode
  localparam int CNT_LSB = 8;      // Command count
  localparam int PREV_BIT = 0;     // Medium removal prevented
  localparam int DATA_BIT = 1;     // Tape holds data
  localparam int BLK_LSB = 0;      // Blocks before gap
  localparam int BLANK_BIT = 16;   // Gap ahead is blank tape
  localparam int FM_LSB = 24;      // Filemarks before blank
  localparam int CHK_BIT = 1;      // Check condition
  localparam int KEY_LSB = 4;      // Sense key
  localparam int FMK_BIT = 8;      // Filemark flag
  localparam int EOM_BIT = 9;      // End of medium flag
  localparam int LST_BIT = 10;     // Logical start flag
  localparam int PEND_BIT = 11;    // Physical end flag
  localparam int SSE_BIT = 12;     // Servo error flag
  localparam int POS_LSB = 16;     // Position code
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Sense keys
  localparam logic [3:0] SK_NONE = 4'h0;
  localparam logic [3:0] SK_NOT_READY = 4'h2;
  localparam logic [3:0] SK_MEDIUM = 4'h3;
  localparam logic [3:0] SK_HARDWARE = 4'h4;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  localparam logic [3:0] SK_BLANK = 4'h8;
  // Tape motion opcodes
  localparam logic [3:0] OP_ERASE = 4'h0;
  localparam logic [3:0] OP_LOAD = 4'h1;
  localparam logic [3:0] OP_UNLOAD = 4'h2;
  localparam logic [3:0] OP_REWIND = 4'h3;
  localparam logic [3:0] OP_READ = 4'h4;
  localparam logic [3:0] OP_FWD_BLK = 4'h5;
  localparam logic [3:0] OP_BACK_BLK = 4'h6;
  localparam logic [3:0] OP_FWD_FM = 4'h7;
  localparam logic [3:0] OP_BACK_FM = 4'h8;
  localparam logic [3:0] OP_WRITE = 4'h9;
  localparam logic [3:0] OP_WRITE_FM = 4'hA;
  // Filemark spans before the end in the long-filemark and data states
  localparam logic [23:0] LONG_FM_SPAN = 24'h000002;
  localparam logic [23:0] DATA_FM_SPAN = 24'h000001;
  // Remembered head position, Gray coded along the usual path
  typedef enum logic [3:0] {
    POS_EJECTED = 4'h0,     // No cartridge in the path
    POS_HELD = 4'h1,        // Unloaded, cartridge kept
    POS_LSTART = 4'h3,      // Logical start
    POS_IN_DATA = 4'h2,     // Read ended within data
    POS_BEFORE_LFM = 4'h6,  // Read ended before a long filemark
    POS_PAST_FM = 4'h7,     // Far side of a filemark
    POS_AFTER_FSB = 4'h5,   // After forward space block
    POS_END_DATA = 4'h4,    // At end of data
    POS_PHYS_END = 4'hC     // At physical tape end
  } pos_type;
  // Outcome of one command
  typedef struct packed {
    logic check;           // Check condition
    logic [3:0] key;       // Sense key
    logic fmk;             // Filemark crossed
    logic eom;             // End of medium
    logic lstart;          // Logical start reached
    logic pend;            // Physical end reached
    logic servo_error_flag;             // Servo error
    logic [23:0] resid;    // Items not found
    pos_type pos;          // Head position afterwards
  } result_type;
endpackage

// *** hw/motion_decide.sv ***
`timescale 1ns/1ps
// Picks status, sense and next position for one motion command
module motion_decide
  import tape_gate_pkg::*;
#(
  parameter int CNT_W = 24  // Count width
)(
  input wire pos_type pos,             // Current position
  input wire logic [3:0] op,           // Opcode
  input wire logic [CNT_W-1:0] cnt,    // Requested count
  input wire logic prevent,            // Removal prevented
  input wire logic has_data,           // Tape holds data
  input wire logic [15:0] blk_avail,   // Blocks before gap
  input wire logic gap_blank,          // Gap is blank tape
  input wire logic [7:0] fm_avail,     // Filemarks before blank
  input wire logic servo_fault,        // Servo fault seen on load
  output result_type res               // Outcome
);
  logic [CNT_W-1:0] blk_w;  // Blocks widened
  logic [CNT_W-1:0] fm_w;   // Filemarks widened
  logic is_fwd;             // Read or forward block
  logic is_back;            // Backward space of either kind

  assign blk_w = CNT_W'(blk_avail);
  assign fm_w = CNT_W'(fm_avail);
  assign is_fwd = (op == OP_READ) || (op == OP_FWD_BLK);
  assign is_back = (op == OP_BACK_BLK) || (op == OP_BACK_FM);

  // Decision table
  always_comb
  begin
    res = '0;
    res.pos = pos;
    if (pos == POS_EJECTED)
    begin
      // Nothing loaded: every motion command is refused
      res.check = 1'b1;
      res.key = SK_NOT_READY;
    end
    else if (op == OP_UNLOAD)
      res.pos = prevent ? POS_HELD : POS_EJECTED;
    else if (op == OP_LOAD)
    begin
      res.pos = POS_LSTART;
      // Early load after unload may fault the servo
      if (pos == POS_HELD && servo_fault)
      begin
        res.check = 1'b1;
        res.key = SK_HARDWARE;
        res.servo_error_flag = 1'b1;
      end
    end
    else if (pos == POS_HELD)
    begin
      res.check = 1'b1;
      res.key = SK_NOT_READY;
    end
    else if (op == OP_REWIND || op == OP_ERASE)
      res.pos = POS_LSTART;
    else
      case (pos)
        POS_LSTART:
        begin
          if (is_back)
          begin
            res.check = 1'b1;
            res.eom = 1'b1;
            res.lstart = 1'b1;
            res.resid = cnt;
          end
          else if (op == OP_WRITE || op == OP_WRITE_FM)
            res.pos = POS_END_DATA;
          else if (!has_data)
          begin
            // Blank tape: nothing to read or space over
            res.check = 1'b1;
            res.key = SK_BLANK;
            res.eom = 1'b1;
            res.lstart = 1'b1;
            res.resid = cnt;
          end
          else if (is_fwd)
          begin
            if (cnt <= blk_w)
              res.pos = POS_IN_DATA;
            else
            begin
              res.check = 1'b1;
              res.resid = cnt - blk_w;
              res.key = gap_blank ? SK_BLANK : SK_NONE;
              res.fmk = !gap_blank;
              res.pos = gap_blank ? POS_END_DATA : POS_PAST_FM;
            end
          end
          else if (op == OP_FWD_FM)
          begin
            if (cnt <= fm_w)
              res.pos = POS_PAST_FM;
            else
            begin
              res.check = 1'b1;
              res.key = SK_MEDIUM;
              res.eom = 1'b1;
              res.pend = 1'b1;
              res.resid = cnt - fm_w;
              res.pos = POS_PHYS_END;
            end
          end
        end
        POS_BEFORE_LFM, POS_IN_DATA, POS_AFTER_FSB:
        begin
          if (is_fwd && (pos == POS_BEFORE_LFM || cnt > blk_w))
          begin
            // Run into the filemark gap and stop beyond it
            res.check = 1'b1;
            res.fmk = 1'b1;
            res.resid = (pos == POS_BEFORE_LFM) ? cnt : cnt - blk_w;
            res.pos = POS_PAST_FM;
          end
          else if (is_fwd)
          begin
            res.pos = (op == OP_FWD_BLK) ? POS_AFTER_FSB : POS_IN_DATA;
            if (op == OP_READ && cnt == blk_w)
              res.pos = POS_BEFORE_LFM;
          end
          else if (op == OP_FWD_FM)
          begin
            if (cnt <= ((pos == POS_BEFORE_LFM) ? LONG_FM_SPAN
                                                : DATA_FM_SPAN))
              res.pos = POS_PAST_FM;
            else
            begin
              res.check = 1'b1;
              res.key = SK_MEDIUM;
              res.eom = 1'b1;
              res.pend = 1'b1;
              res.resid = cnt - ((pos == POS_BEFORE_LFM) ? LONG_FM_SPAN
                                                         : DATA_FM_SPAN);
              res.pos = POS_PHYS_END;
            end
          end
          else if (op == OP_WRITE || op == OP_WRITE_FM)
          begin
            if (pos == POS_BEFORE_LFM)
              res.pos = POS_END_DATA;
            else
            begin
              // Overwrite inside data is illegal; head stays put
              res.check = 1'b1;
              res.key = SK_ILLEGAL;
            end
          end
        end
        default:
          // Other positions: Good status; only a write moves the head, to end of data
          res.pos = (op == OP_WRITE) ? POS_END_DATA : pos;
      endcase
  end
endmodule

// *** hw/tape_position_command_gate.sv ***
`timescale 1ns/1ps
// Function
// - Eject on unload; then every command Not Ready
// - Held unload: only load and unload accepted
// - Load servo fault gives Hardware Error, flag
// - Before long filemark: read crosses, FMK set
// - Long filemark: space one or two filemarks
// - Long filemark: write appends, erases beyond
// - Long filemark: filemark write erases beyond
// - In data: read fits, else crosses filemark
// - In data: one filemark spaces, more hits end
// - In data: writes illegal, no motion
// - Rewind reaches logical start; writes valid there
// - Rewind or load at start: Good, no motion
// - Start on blank: read gives Blank Check
// - Start with data: oversized read stops early
// - Start on blank: filemark space Blank Check
// - Start with data: excess filemarks hit end
// - Start: backward space gives No Sense
module tape_position_command_gate
  import tape_gate_pkg::*;
#(
  parameter int CNT_W = 24  // Count width
)(
  input wire logic aclk,                // Clock
  input wire logic aresetn,             // Sync reset, active low
  input wire logic [7:0] s_axi_awaddr,  // Write address
  input wire logic s_axi_awvalid,       // Write address valid
  output logic s_axi_awready,           // Write address ready
  input wire logic [31:0] s_axi_wdata,  // Write data
  input wire logic [3:0] s_axi_wstrb,   // Write strobes
  input wire logic s_axi_wvalid,        // Write data valid
  output logic s_axi_wready,            // Write data ready
  output logic [1:0] s_axi_bresp,       // Write response
  output logic s_axi_bvalid,            // Write response valid
  input wire logic s_axi_bready,        // Write response ready
  input wire logic [7:0] s_axi_araddr,  // Read address
  input wire logic s_axi_arvalid,       // Read address valid
  output logic s_axi_arready,           // Read address ready
  output logic [31:0] s_axi_rdata,      // Read data
  output logic [1:0] s_axi_rresp,       // Read response
  output logic s_axi_rvalid,            // Read data valid
  input wire logic s_axi_rready,        // Read data ready
  input wire logic servo_fault,         // Servo fault pin, async
  output logic cmd_done,                // Command finished pulse
  output logic check_cond               // Last status was check
);
  // Bus state
  logic aw_have, next_aw_have;          // Address held
  logic w_have, next_w_have;            // Data held
  logic [7:0] wa, next_wa;              // Held write address
  logic [31:0] wd, next_wd;             // Held write data
  logic [3:0] ws, next_ws;              // Held strobes
  logic next_awready, next_wready, next_arready;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  // Software registers
  logic [31:0] cmd, next_cmd;           // Latched command
  logic [31:0] ctrl, next_ctrl;         // Control bits
  logic [31:0] media, next_media;       // Media layout
  logic cmd_go, next_cmd_go;            // Evaluate this cycle
  // Block state
  pos_type pos, next_pos;               // Head position
  result_type last, next_last;          // Last outcome
  logic next_done;
  result_type res;                      // Decision
  logic fault_s1, fault_s2;             // Servo fault sync
  logic do_write;                       // Write completes now

  // Maps a byte address to a register index, or 7 if unmapped
  function automatic logic [2:0] reg_index(input logic [7:0] a);
    case (a)
      CMD_OFS: reg_index = 3'h0;
      CTRL_OFS: reg_index = 3'h1;
      MEDIA_OFS: reg_index = 3'h2;
      STAT_OFS: reg_index = 3'h3;
      RESID_OFS: reg_index = 3'h4;
      default: reg_index = 3'h7;
    endcase
  endfunction

  // Byte-enable merge for writable registers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  // Status word assembly
  function automatic logic [31:0] status_word(input result_type r,
                                              input pos_type p);
    status_word = '0;
    status_word[CHK_BIT] = r.check;
    status_word[KEY_LSB +: 4] = r.key;
    status_word[FMK_BIT] = r.fmk;
    status_word[EOM_BIT] = r.eom;
    status_word[LST_BIT] = r.lstart;
    status_word[PEND_BIT] = r.pend;
    status_word[SSE_BIT] = r.servo_error_flag;
    status_word[POS_LSB +: 4] = p;
  endfunction

  // Servo fault synchroniser
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault_s1 <= 1'b0;
      fault_s2 <= 1'b0;
    end
    else
    begin
      fault_s1 <= servo_fault;
      fault_s2 <= fault_s1;
    end
  end

  // Decision logic
  motion_decide #(.CNT_W(CNT_W)) decide (
    .pos(pos),
    .op(cmd[OP_LSB +: 4]),
    .cnt(cmd[CNT_LSB +: CNT_W]),
    .prevent(ctrl[PREV_BIT]),
    .has_data(ctrl[DATA_BIT]),
    .blk_avail(media[BLK_LSB +: 16]),
    .gap_blank(media[BLANK_BIT]),
    .fm_avail(media[FM_LSB +: 8]),
    .servo_fault(fault_s2),
    .res(res)
  );

  assign do_write = aw_have && w_have && !s_axi_bvalid;

  // Bus and register next values
  always_comb
  begin
    next_aw_have = aw_have;
    next_w_have = w_have;
    next_wa = wa;
    next_wd = wd;
    next_ws = ws;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    next_cmd = cmd;
    next_ctrl = ctrl;
    next_media = media;
    next_cmd_go = 1'b0;
    // Address and data taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_have = 1'b1;
      next_wa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_have = 1'b1;
      next_wd = s_axi_wdata;
      next_ws = s_axi_wstrb;
    end
    // Response retires
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    // Both halves present: perform the write
    if (do_write)
    begin
      next_aw_have = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (reg_index(wa))
        3'h0:
        begin
          // Command launch; evaluated next cycle
          next_cmd = merge(cmd, wd, ws);
          next_cmd_go = 1'b1;
        end
        3'h1: next_ctrl = merge(ctrl, wd, ws);
        3'h2: next_media = merge(media, wd, ws);
        3'h3, 3'h4: next_bresp = RESP_OKAY; // Read-only, ignored
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    // Read path
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      case (reg_index(s_axi_araddr))
        3'h0: next_rdata = cmd;
        3'h1: next_rdata = ctrl;
        3'h2: next_rdata = media;
        3'h3: next_rdata = status_word(last, pos);
        3'h4: next_rdata = 32'(last.resid);
        default:
        begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    next_awready = !next_aw_have && !next_bvalid;
    next_wready = !next_w_have && !next_bvalid;
    next_arready = !next_rvalid;
  end

  // Bus and register flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      wa <= 8'h00;
      wd <= 32'h00000000;
      ws <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      cmd <= 32'h00000000;
      ctrl <= 32'h00000000;
      media <= 32'h00000000;
      cmd_go <= 1'b0;
    end
    else
    begin
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      wa <= next_wa;
      wd <= next_wd;
      ws <= next_ws;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_arready <= next_arready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      cmd <= next_cmd;
      ctrl <= next_ctrl;
      media <= next_media;
      cmd_go <= next_cmd_go;
    end
  end

  // Position and outcome next values
  always_comb
  begin
    next_pos = pos;
    next_last = last;
    next_done = 1'b0;
    if (cmd_go)
    begin
      next_pos = res.pos;
      next_last = res;
      next_done = 1'b1;
    end
  end

  // Position and outcome flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pos <= POS_HELD;  // Cartridge in, tape not loaded
      last <= '0;
      cmd_done <= 1'b0;
      check_cond <= 1'b0;
    end
    else
    begin
      pos <= next_pos;
      last <= next_last;
      cmd_done <= next_done;
      check_cond <= next_last.check;
    end
  end

  // Checks
  eject_not_ready_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && pos == POS_EJECTED |=> check_cond && last.key == SK_NOT_READY
    && pos == POS_EJECTED)
    else $error("ejected drive accepted a command");
  held_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && pos == POS_HELD && cmd[OP_LSB +: 4] == OP_READ
    |=> last.key == SK_NOT_READY && pos == POS_HELD)
    else $error("held drive accepted a read");
  servo_fault_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && pos == POS_HELD && cmd[OP_LSB +: 4] == OP_LOAD && fault_s2
    |=> last.key == SK_HARDWARE && last.servo_error_flag && check_cond)
    else $error("servo fault not reported");
  long_fm_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && pos == POS_BEFORE_LFM && cmd[OP_LSB +: 4] == OP_FWD_FM
    && cmd[CNT_LSB +: CNT_W] > LONG_FM_SPAN
    |=> pos == POS_PHYS_END && last.key == SK_MEDIUM && last.pend)
    else $error("excess filemark space missed end");
  write_illegal_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && pos == POS_IN_DATA && cmd[OP_LSB +: 4] == OP_WRITE
    |=> last.key == SK_ILLEGAL && $stable(pos))
    else $error("write inside data not refused");
  start_good_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && pos == POS_LSTART && cmd[OP_LSB +: 4] == OP_REWIND
    |=> !check_cond && pos == POS_LSTART ##1 cmd_done == 1'b0)
    else $error("rewind at start not good");
  blank_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && pos == POS_LSTART && !ctrl[DATA_BIT]
    && cmd[OP_LSB +: 4] == OP_READ
    |=> last.key == SK_BLANK && last.eom && last.lstart
    && last.resid == $past(cmd[CNT_LSB +: CNT_W]))
    else $error("blank read outcome wrong");
  back_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && pos == POS_LSTART && cmd[OP_LSB +: 4] == OP_BACK_FM
    |=> last.key == SK_NONE && last.eom && last.lstart && check_cond)
    else $error("backward space at start wrong");
  done_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go |=> cmd_done ##1 !cmd_done)
    else $error("command completion pulse wrong");
endmodule

// *** bench/servo_partner.sv ***
`timescale 1ns/1ps
// Servo seen from the initiator: loading too soon after unload upsets it
module servo_partner (
  input wire logic aclk,     // Clock
  input wire logic aresetn,  // Sync reset, active low
  input wire logic early,    // Load issued before the settle time
  output logic servo_fault   // Servo fault level
);
  logic next_fault;  // Next fault level
  // Fault follows a premature load
  always_comb next_fault = aresetn & early;
  // Register the fault level
  always_ff @(posedge aclk) servo_fault <= next_fault;
endmodule

// *** bench/tape_position_command_gate_bench.sv ***
`timescale 1ns/1ps
module tape_position_command_gate_bench;
  import tape_gate_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, early;
  logic awready, wready, bvalid, arready, rvalid;
  logic servo_fault, cmd_done, check_cond;
  logic [7:0] awaddr, araddr;  // Bus addresses
  logic [31:0] wdata, rdata, got;  // Bus data
  logic [3:0] wstrb;  // Byte enables
  logic [1:0] bresp, rresp, resp;  // Responses
  int errors, checked, cycles, dones;
  tape_position_command_gate tape_position_command_gate_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .servo_fault(servo_fault), .cmd_done(cmd_done),
    .check_cond(check_cond));
  servo_partner servo_partner_i (.aclk(aclk), .aresetn(aresetn),
    .early(early), .servo_fault(servo_fault));
  // Free running clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Cycle watchdog and completion pulse counter
  always @(posedge aclk)
  begin
    cycles++;
    if (cmd_done === 1'b1) dones++;
    if (cycles == 20000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One write; address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  // One read; data taken at the rvalid edge
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // Status word layout: position, flags, sense key, check
  function automatic logic [31:0] sw(input logic c, input logic [3:0] k,
                                     input logic [4:0] f, input pos_type p);
    return {12'h000, p, 3'h0, f, k, 2'h0, c, 1'b0};
  endfunction
  // One command, then status, residual and check_cond compared
  task automatic run(input logic [3:0] op, input logic [23:0] n,
                     input logic [3:0] k, input logic [4:0] f,
                     input pos_type p, input logic [23:0] rs);
    logic c;
    c = (k != SK_NONE) || (f != 5'h00);
    wr(CMD_OFS, {n, 4'h0, op}, 4'hF);
    rd(STAT_OFS);
    cmp(got, sw(c, k, f, p));
    rd(RESID_OFS);
    cmp(got, {8'h00, rs});
    cmp({31'h0, check_cond}, {31'h0, c});
  endtask
  // Command expected to end with Good status
  task automatic good(input logic [3:0] op, input logic [23:0] n,
                      input pos_type p);
    run(op, n, SK_NONE, 5'h00, p, 24'h0);
  endtask
  // Rewind, then read up to the long filemark
  task automatic to_lfm();
    good(OP_REWIND, 24'h0, POS_LSTART);
    good(OP_READ, 24'h1, POS_IN_DATA);
    good(OP_READ, 24'h5, POS_BEFORE_LFM);
  endtask
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, early} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(STAT_OFS);
    cmp(got, sw(1'b0, SK_NONE, 5'h00, POS_HELD));
    // Register access: byte enables, read-only and unmapped places
    wr(MEDIA_OFS, 32'h0200_00FF, 4'hF);
    wr(MEDIA_OFS, 32'hFFFF_FF05, 4'h1);
    rd(MEDIA_OFS);
    cmp(got, 32'h0200_0005);
    wr(STAT_OFS, 32'hFFFF_FFFF, 4'hF);
    cmp({30'h0, resp}, {30'h0, RESP_OKAY});
    rd(STAT_OFS);
    cmp(got, sw(1'b0, SK_NONE, 5'h00, POS_HELD));
    wr(8'h14, 32'h1, 4'hF);
    cmp({30'h0, resp}, {30'h0, RESP_SLVERR});
    rd(8'h14);
    cmp({30'h0, resp}, {30'h0, RESP_SLVERR});
    cmp(got, 32'h0);
    // Held cartridge, then the logical start with data
    wr(CTRL_OFS, 32'h0000_0003, 4'hF);
    run(OP_READ, 24'h3, SK_NOT_READY, 5'h00, POS_HELD, 24'h0);
    early <= 1'b1;
    repeat (3) @(posedge aclk);
    run(OP_LOAD, 24'h0, SK_HARDWARE, 5'h10, POS_LSTART, 24'h0);
    early <= 1'b0;
    good(OP_REWIND, 24'h0, POS_LSTART);
    good(OP_LOAD, 24'h0, POS_LSTART);
    run(OP_BACK_FM, 24'h4, SK_NONE, 5'h06, POS_LSTART, 24'h4);
    run(OP_READ, 24'h7, SK_NONE, 5'h01, POS_PAST_FM, 24'h2);
    good(OP_REWIND, 24'h0, POS_LSTART);
    run(OP_FWD_FM, 24'h3, SK_MEDIUM, 5'h0A, POS_PHYS_END, 24'h1);
    good(OP_ERASE, 24'h0, POS_LSTART);
    good(OP_FWD_FM, 24'h2, POS_PAST_FM);
    // Before the long filemark
    to_lfm();
    run(OP_FWD_FM, 24'h3, SK_MEDIUM, 5'h0A, POS_PHYS_END, 24'h1);
    to_lfm();
    good(OP_FWD_FM, 24'h2, POS_PAST_FM);
    to_lfm();
    run(OP_FWD_BLK, 24'h4, SK_NONE, 5'h01, POS_PAST_FM, 24'h4);
    to_lfm();
    good(OP_WRITE, 24'h0, POS_END_DATA);
    to_lfm();
    good(OP_WRITE_FM, 24'h0, POS_END_DATA);
    // Inside data and after a forward block
    good(OP_REWIND, 24'h0, POS_LSTART);
    good(OP_READ, 24'h1, POS_IN_DATA);
    run(OP_WRITE, 24'h0, SK_ILLEGAL, 5'h00, POS_IN_DATA, 24'h0);
    good(OP_FWD_BLK, 24'h2, POS_AFTER_FSB);
    run(OP_WRITE_FM, 24'h0, SK_ILLEGAL, 5'h00, POS_AFTER_FSB, 24'h0);
    good(OP_FWD_FM, 24'h1, POS_PAST_FM);
    good(OP_REWIND, 24'h0, POS_LSTART);
    good(OP_READ, 24'h1, POS_IN_DATA);
    run(OP_READ, 24'h6, SK_NONE, 5'h01, POS_PAST_FM, 24'h1);
    good(OP_REWIND, 24'h0, POS_LSTART);
    good(OP_READ, 24'h1, POS_IN_DATA);
    run(OP_FWD_FM, 24'h2, SK_MEDIUM, 5'h0A, POS_PHYS_END, 24'h1);
    // Blank tape at the logical start
    wr(CTRL_OFS, 32'h0000_0001, 4'hF);
    good(OP_REWIND, 24'h0, POS_LSTART);
    run(OP_READ, 24'h4, SK_BLANK, 5'h06, POS_LSTART, 24'h4);
    run(OP_FWD_FM, 24'h3, SK_BLANK, 5'h06, POS_LSTART, 24'h3);
    good(OP_WRITE_FM, 24'h0, POS_END_DATA);
    // Data running into blank tape, then both kinds of unload
    wr(CTRL_OFS, 32'h0000_0003, 4'hF);
    wr(MEDIA_OFS, 32'h0001_0000, 4'h4);
    good(OP_REWIND, 24'h0, POS_LSTART);
    run(OP_READ, 24'h9, SK_BLANK, 5'h00, POS_END_DATA, 24'h4);
    good(OP_UNLOAD, 24'h0, POS_HELD);
    good(OP_LOAD, 24'h0, POS_LSTART);
    wr(CTRL_OFS, 32'h0000_0002, 4'hF);
    good(OP_UNLOAD, 24'h0, POS_EJECTED);
    // Ejected: every opcode is Not Ready, head stays put
    for (int pv = 0; pv < 2; pv++)
    begin
      wr(CTRL_OFS, {30'h0, 1'b1, pv[0]}, 4'hF);
      rd(CTRL_OFS);
      cmp(got, {30'h0, 1'b1, pv[0]});
      for (int op = 0; op <= 10; op++)
      begin
        early <= (op == 1);
        repeat (3) @(posedge aclk);
        wr(CMD_OFS, {24'h000003, 4'h0, op[3:0]}, 4'hF);
        repeat (2) @(posedge aclk);
        rd(STAT_OFS);
        cmp(got, sw(1'b1, SK_NOT_READY, 5'h00, POS_EJECTED));
        cmp({31'h0, check_cond}, 32'h1);
      end
    end
    early <= 1'b0;
    cmp(dones, 73);
    // Reset in mid-run: cartridge held again, controls cleared
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(STAT_OFS);
    cmp(got, sw(1'b0, SK_NONE, 5'h00, POS_HELD));
    rd(CTRL_OFS);
    cmp(got, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
